// >>> nbm_pkg.sv
package nbm_pkg;

  // ---------------------------------------------------------------
  // Clock
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 200;

  // ---------------------------------------------------------------
  // Pin timing, in ns, and derived cycle counts
  // ---------------------------------------------------------------
  localparam int T_WP_NS = 12;
  localparam int T_ADL_NS = 70;
  localparam int T_REA_NS = 20;
  localparam int T_REH_NS = 10;
  localparam int T_WB_NS = 100;
  localparam int T_WHR_NS = 60;
  localparam int T_RHW_NS = 100;
  localparam logic [4:0] WLO_CYC = 5'((T_WP_NS * CLK_MHZ + 999) / 1000);
  localparam logic [4:0] WCYC = 5'((T_ADL_NS * CLK_MHZ + 999) / 1000);
  // Read strobe low also covers the two-stage input sampler and output flop
  localparam logic [4:0] RLO_CYC = 5'((T_REA_NS * CLK_MHZ + 999) / 1000 + 3);
  localparam logic [4:0] RCYC = 5'(RLO_CYC + 5'((T_REH_NS * CLK_MHZ + 999) / 1000));
  localparam logic [4:0] WB_CYC = 5'((T_WB_NS * CLK_MHZ + 999) / 1000);
  localparam logic [4:0] WHR_CYC = 5'((T_WHR_NS * CLK_MHZ + 999) / 1000);
  localparam logic [4:0] RHW_CYC = 5'((T_RHW_NS * CLK_MHZ + 999) / 1000);

  // ---------------------------------------------------------------
  // Busy maxima, in us (multiplied by CLK_MHZ to cycles, no rounding)
  // ---------------------------------------------------------------
  localparam int T_R_US = 25;
  localparam int T_PROG_US = 700;
  localparam int T_BERS_US = 10000;
  localparam int T_RST_US = 500;
  localparam int T_FEAT_US = 1;
  localparam logic [21:0] FEAT_TMO_CYC = 22'(T_FEAT_US * CLK_MHZ);

  // ---------------------------------------------------------------
  // Commands, status and array figures
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_READ1 = 8'h00;
  localparam logic [7:0] CMD_READ2 = 8'h30;
  localparam logic [7:0] CMD_PROG1 = 8'h80;
  localparam logic [7:0] CMD_PROG2 = 8'h10;
  localparam logic [7:0] CMD_ERASE1 = 8'h60;
  localparam logic [7:0] CMD_ERASE2 = 8'hd0;
  localparam logic [7:0] CMD_RESET = 8'hff;
  localparam logic [7:0] CMD_SETF = 8'hef;
  localparam logic [7:0] CMD_GETF = 8'hee;
  localparam logic [7:0] CMD_STATUS = 8'h70;
  localparam int STS_RDY_BIT = 5;
  localparam int STS_FAIL_BIT = 0;
  localparam logic [7:0] MARK_GOOD = 8'hff;
  localparam logic [11:0] SPARE_COL = 12'h800;
  localparam logic [9:0] ECC_CHUNK = 10'h210;
  localparam logic [2:0] PARTIAL_PROGRAM_LIMIT = 3'h4;
  localparam logic [11:0] FEAT_LEN = 12'h004;
  localparam int FIFO_WIDTH = 8;
  localparam int FIFO_DEPTH = 16;

  // ---------------------------------------------------------------
  // Operations and sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_READ = 3'h0,
    OP_PROG = 3'h1,
    OP_ERASE = 3'h2,
    OP_RESET = 3'h3,
    OP_SETF = 3'h4,
    OP_GETF = 3'h5
  } nbm_op_e;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_CMD1 = 4'h1,
    ST_ADDR = 4'h2,
    ST_WDATA = 4'h3,
    ST_CMD2 = 4'h4,
    ST_WB = 4'h5,
    ST_BUSY = 4'h6,
    ST_SCMD = 4'h7,
    ST_WHR = 4'h8,
    ST_SREAD = 4'h9,
    ST_RDATA = 4'ha,
    ST_RHW = 4'hb,
    ST_DONE = 4'hc
  } nbm_state_e;

endpackage : nbm_pkg

// >>> nbm_fifo.sv
`timescale 1ns/1ps
module nbm_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0] cnt_q;
  logic empty_q;
  logic [AW:0] cnt_d;
  wire push = in_valid && in_ready;
  wire pop = out_ready && !empty_q;

  assign out_valid = !empty_q;
  assign out_data = mem_q[rp_q];
  assign cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);

  always_ff @(posedge clk) begin
    if (srst) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
      in_ready <= 1'b1;
      empty_q <= 1'b1;
    end else if (ce) begin
      if (push) begin
        wp_q <= wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= rp_q + 1'b1;
      end
      cnt_q <= cnt_d;
      in_ready <= cnt_d != (AW+1)'(DEPTH);
      empty_q <= cnt_d == '0;
    end
  end

  always_ff @(posedge clk) begin
    if (ce && push) begin
      mem_q[wp_q] <= in_data;
    end
  end

endmodule : nbm_fifo

// >>> nbm_host.sv
// Contract
// - Busy falls within 100 ns of last write strobe; no command then.
// - Program one page at most four times before erasing its block.
// - Program pages within a block in strictly ascending order; code refuses only a page below the last programmed.
// - Read bad-block marks before any program or erase.
// - Read status after program or erase; retire failing blocks.
// - Correct at least one bit per 528 bytes read.
// - Replacement copies earlier pages, writes page n from buffer, marks bad.
// - Status bit 5 shows completion, polled with command 70h.
// - Write protect stays stable through an operation; low refuses changes.
`timescale 1ns/1ps
module nbm_host import nbm_pkg::*; #(
  parameter int unsigned READ_TMO_CYC = T_R_US * CLK_MHZ,
  parameter int unsigned PROG_TMO_CYC = T_PROG_US * CLK_MHZ,
  parameter int unsigned ERASE_TMO_CYC = T_BERS_US * CLK_MHZ,
  parameter int unsigned RESET_TMO_CYC = T_RST_US * CLK_MHZ
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [2:0] cmd_op,
  input wire logic [10:0] cmd_block,
  input wire logic [5:0] cmd_page,
  input wire logic [11:0] cmd_col,
  input wire logic [11:0] cmd_len,
  input wire logic wp_allow,
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [7:0] wr_data,
  output logic rd_valid,
  output logic [7:0] rd_data,
  output logic done,
  output logic [7:0] status_byte,
  output logic err_timeout,
  output logic err_fail,
  output logic err_order,
  output logic err_nop,
  output logic err_refused,
  output logic mark_bad,
  output logic ecc_valid,
  output logic [17:0] ecc_syn,
  output logic nf_ce_n,
  output logic nf_cle,
  output logic nf_ale,
  output logic nf_we_n,
  output logic read_strobe_n,
  output logic nf_wp_n,
  output logic [7:0] nf_dq_o,
  output logic nf_dq_oe,
  input wire logic [7:0] nf_dq_i,
  input wire logic nf_rb_n
);

  // ---------------------------------------------------------------
  // State and input samplers
  // ---------------------------------------------------------------
  nbm_state_e state_q, state_d;
  nbm_op_e op_q;
  logic [10:0] blk_q;
  logic [5:0] pg_q;
  logic [11:0] col_q, len_q, cnt_q, cnt_d;
  logic [4:0] ph_q, ph_d;
  logic [2:0] ai_q, ai_d;
  logic [21:0] wt_q, wt_d;
  logic [1:0] rb_sync_q;
  logic [7:0] dq_s1_q, dq_s2_q;
  logic trk_vld_q;
  logic [10:0] trk_blk_q;
  logic [5:0] trk_pg_q;
  logic [2:0] trk_cnt_q;
  logic [9:0] ecc_idx_q, posx_q;
  logic [7:0] colx_q;
  logic fifo_v;
  logic [7:0] fifo_d;

  always_ff @(posedge clk) begin
    if (srst) begin
      rb_sync_q <= 2'h0;
      dq_s1_q <= 8'h00;
      dq_s2_q <= 8'h00;
    end else if (ce) begin
      rb_sync_q <= {rb_sync_q[0], nf_rb_n};
      dq_s1_q <= nf_dq_i;
      dq_s2_q <= dq_s1_q;
    end
  end

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  wire nbm_op_e cop = nbm_op_e'(cmd_op);
  wire accept = cmd_valid && cmd_ready && state_q == ST_IDLE;
  wire same_blk = trk_vld_q && cmd_block == trk_blk_q;
  wire same_pg = same_blk && cmd_page == trk_pg_q;
  wire is_rw = cop == OP_READ || cop == OP_PROG;
  wire op_bad = cmd_op > 3'h5;
  wire prot_bad = (cop == OP_PROG || cop == OP_ERASE) && !wp_allow;
  wire order_bad = cop == OP_PROG && same_blk && cmd_page < trk_pg_q;
  wire nop_bad = cop == OP_PROG && same_pg && trk_cnt_q == PARTIAL_PROGRAM_LIMIT;
  wire refuse = op_bad || prot_bad || (is_rw && cmd_len == 12'h000);
  wire reject = refuse || order_bad || nop_bad;

  wire [16:0] row = {blk_q, pg_q};
  wire [7:0] cmd1_code = op_q == OP_READ ? CMD_READ1 : op_q == OP_PROG ? CMD_PROG1 :
                         op_q == OP_ERASE ? CMD_ERASE1 : op_q == OP_RESET ? CMD_RESET :
                         op_q == OP_SETF ? CMD_SETF : CMD_GETF;
  wire [7:0] cmd2_code = op_q == OP_READ ? CMD_READ2 : op_q == OP_PROG ? CMD_PROG2 : CMD_ERASE2;
  wire [2:0] n_addr = (op_q == OP_READ || op_q == OP_PROG) ? 3'h5 : op_q == OP_ERASE ? 3'h3 :
                      op_q == OP_RESET ? 3'h0 : 3'h1;
  wire [2:0] addr_sel = op_q == OP_ERASE ? ai_q + 3'h2 : ai_q;
  wire [7:0] addr_byte = addr_sel == 3'h0 ? col_q[7:0] : addr_sel == 3'h1 ? {4'h0, col_q[11:8]} :
                         addr_sel == 3'h2 ? row[7:0] : addr_sel == 3'h3 ? row[15:8] : {7'h00, row[16]};
  wire [21:0] tmo_lim = op_q == OP_READ || op_q == OP_GETF ? 22'(READ_TMO_CYC) :
                        op_q == OP_PROG ? 22'(PROG_TMO_CYC) : op_q == OP_ERASE ? 22'(ERASE_TMO_CYC) :
                        op_q == OP_RESET ? 22'(RESET_TMO_CYC) : FEAT_TMO_CYC;
  wire tmo = wt_q >= tmo_lim;
  wire polled = op_q != OP_READ && op_q != OP_GETF;
  wire wr_st = state_q == ST_CMD1 || state_q == ST_ADDR || state_q == ST_WDATA ||
               state_q == ST_CMD2 || state_q == ST_SCMD;
  wire rd_st = state_q == ST_SREAD || state_q == ST_RDATA;
  wire wstall = state_q == ST_WDATA && ph_q == 5'h00 && !fifo_v;
  wire pop = state_q == ST_WDATA && ph_q == 5'h00 && fifo_v;
  wire w_last = ph_q == WCYC - 5'h01;
  wire r_cap = rd_st && ph_q == RLO_CYC - 5'h01;
  wire r_last = ph_q == RCYC - 5'h01;
  wire [7:0] out_byte = state_q == ST_CMD1 ? cmd1_code : state_q == ST_ADDR ? addr_byte :
                        state_q == ST_WDATA ? fifo_d : state_q == ST_CMD2 ? cmd2_code : CMD_STATUS;
  wire dat_cap = r_cap && state_q == ST_RDATA;
  wire [7:0] colx_n = colx_q ^ dq_s2_q;
  wire [9:0] posx_n = posx_q ^ (^dq_s2_q ? ecc_idx_q : 10'h000);
  wire chunk_end = ecc_idx_q == ECC_CHUNK - 10'h001 || cnt_q == len_q - 12'h001;

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    ph_d = ph_q + 5'h01;
    ai_d = ai_q;
    cnt_d = cnt_q;
    wt_d = wt_q + 22'h000001;
    unique case (state_q)
      ST_IDLE: begin
        ph_d = 5'h00;
        ai_d = 3'h0;
        cnt_d = 12'h000;
        wt_d = 22'h000000;
        if (accept) begin
          state_d = reject ? ST_DONE : ST_CMD1;
        end
      end
      ST_CMD1: if (w_last) begin
        ph_d = 5'h00;
        state_d = n_addr != 3'h0 ? ST_ADDR : ST_WB;
      end
      ST_ADDR: if (w_last) begin
        ph_d = 5'h00;
        ai_d = ai_q + 3'h1;
        if (ai_q == n_addr - 3'h1) begin
          state_d = (op_q == OP_PROG || op_q == OP_SETF) ? ST_WDATA :
                    op_q == OP_GETF ? ST_WB : ST_CMD2;
        end
      end
      ST_WDATA: begin
        if (wstall) begin
          ph_d = 5'h00;
        end else if (w_last) begin
          ph_d = 5'h00;
          cnt_d = cnt_q + 12'h001;
          if (cnt_q == len_q - 12'h001) begin
            state_d = op_q == OP_SETF ? ST_WB : ST_CMD2;
          end
        end
      end
      ST_CMD2: if (w_last) begin
        ph_d = 5'h00;
        state_d = ST_WB;
      end
      ST_WB: if (ph_q == WB_CYC - 5'h01) begin
        wt_d = 22'h000000;
        state_d = ST_BUSY;
      end
      ST_BUSY: begin
        ph_d = 5'h00;
        if (tmo) begin
          state_d = ST_RHW;
        end else if (rb_sync_q[1]) begin
          state_d = polled ? ST_SCMD : ST_WHR;
        end
      end
      ST_SCMD: if (w_last) begin
        ph_d = 5'h00;
        state_d = ST_WHR;
      end
      ST_WHR: if (ph_q == WHR_CYC - 5'h01) begin
        ph_d = 5'h00;
        state_d = polled ? ST_SREAD : ST_RDATA;
      end
      ST_SREAD: if (r_last) begin
        ph_d = 5'h00;
        if (status_byte[STS_RDY_BIT] || tmo) begin
          state_d = ST_RHW;
        end
      end
      ST_RDATA: if (r_last) begin
        ph_d = 5'h00;
        cnt_d = cnt_q + 12'h001;
        if (cnt_q == len_q - 12'h001) begin
          state_d = ST_RHW;
        end
      end
      ST_RHW: if (ph_q == RHW_CYC - 5'h01) begin
        state_d = ST_DONE;
      end
      ST_DONE: state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_q <= ST_IDLE;
      ph_q <= 5'h00;
      ai_q <= 3'h0;
      cnt_q <= 12'h000;
      wt_q <= 22'h000000;
      cmd_ready <= 1'b0;
    end else if (ce) begin
      state_q <= state_d;
      ph_q <= ph_d;
      ai_q <= ai_d;
      cnt_q <= cnt_d;
      wt_q <= wt_d;
      cmd_ready <= state_d == ST_IDLE;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      op_q <= OP_READ;
      blk_q <= 11'h000;
      pg_q <= 6'h00;
      col_q <= 12'h000;
      len_q <= 12'h000;
    end else if (ce && accept) begin
      op_q <= cop;
      blk_q <= cmd_block;
      pg_q <= cmd_page;
      col_q <= cmd_col;
      len_q <= (cop == OP_SETF || cop == OP_GETF) ? FEAT_LEN : cmd_len;
    end
  end

  // ---------------------------------------------------------------
  // Block programming order tracker
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      trk_vld_q <= 1'b0;
      trk_blk_q <= 11'h000;
      trk_pg_q <= 6'h00;
      trk_cnt_q <= 3'h0;
    end else if (ce && accept && !reject) begin
      if (cop == OP_PROG) begin
        trk_vld_q <= 1'b1;
        trk_blk_q <= cmd_block;
        trk_pg_q <= cmd_page;
        trk_cnt_q <= same_pg ? trk_cnt_q + 3'h1 : 3'h1;
      end else if (cop == OP_ERASE && same_blk) begin
        trk_vld_q <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Results, read data and error syndrome
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      done <= 1'b0;
      status_byte <= 8'h00;
      err_timeout <= 1'b0;
      err_fail <= 1'b0;
      err_order <= 1'b0;
      err_nop <= 1'b0;
      err_refused <= 1'b0;
      mark_bad <= 1'b0;
      rd_valid <= 1'b0;
      rd_data <= 8'h00;
    end else if (ce) begin
      done <= state_q == ST_DONE;
      rd_valid <= dat_cap;
      if (accept) begin
        status_byte <= 8'h00;
        err_timeout <= 1'b0;
        err_fail <= 1'b0;
        err_order <= order_bad;
        err_nop <= nop_bad;
        err_refused <= refuse;
        mark_bad <= 1'b0;
      end
      if (r_cap && state_q == ST_SREAD) begin
        status_byte <= dq_s2_q;
      end
      if (state_q == ST_SREAD && r_last && status_byte[STS_RDY_BIT] &&
          (op_q == OP_PROG || op_q == OP_ERASE)) begin
        err_fail <= status_byte[STS_FAIL_BIT];
      end
      if (((state_q == ST_BUSY) || (state_q == ST_SREAD && r_last && !status_byte[STS_RDY_BIT])) && tmo) begin
        err_timeout <= 1'b1;
      end
      if (dat_cap) begin
        rd_data <= dq_s2_q;
        if (cnt_q == 12'h000 && col_q == SPARE_COL && op_q == OP_READ) begin
          mark_bad <= dq_s2_q != MARK_GOOD;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ecc_idx_q <= 10'h000;
      colx_q <= 8'h00;
      posx_q <= 10'h000;
      ecc_syn <= 18'h00000;
      ecc_valid <= 1'b0;
    end else if (ce) begin
      ecc_valid <= dat_cap && chunk_end;
      if (accept || (dat_cap && chunk_end)) begin
        ecc_idx_q <= 10'h000;
        colx_q <= 8'h00;
        posx_q <= 10'h000;
      end else if (dat_cap) begin
        ecc_idx_q <= ecc_idx_q + 10'h001;
        colx_q <= colx_n;
        posx_q <= posx_n;
      end
      if (dat_cap && chunk_end) begin
        ecc_syn <= {posx_n, colx_n};
      end
    end
  end

  // ---------------------------------------------------------------
  // Pins
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      nf_ce_n <= 1'b1;
      nf_cle <= 1'b0;
      nf_ale <= 1'b0;
      nf_we_n <= 1'b1;
      read_strobe_n <= 1'b1;
      nf_wp_n <= 1'b0;
      nf_dq_o <= 8'h00;
      nf_dq_oe <= 1'b0;
    end else if (ce) begin
      // Refused requests pass through the final state without selecting the device
      nf_ce_n <= state_q == ST_IDLE || state_q == ST_DONE;
      nf_cle <= state_q == ST_CMD1 || state_q == ST_CMD2 || state_q == ST_SCMD;
      nf_ale <= state_q == ST_ADDR;
      nf_we_n <= !(wr_st && !wstall && ph_q < WLO_CYC);
      read_strobe_n <= !(rd_st && ph_q < RLO_CYC);
      nf_dq_oe <= wr_st;
      if (wr_st && ph_q == 5'h00) begin
        nf_dq_o <= out_byte;
      end
      if (state_q == ST_IDLE) begin
        nf_wp_n <= wp_allow;
      end
    end
  end

  nbm_fifo #(
    .WIDTH(FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_wr_fifo (
    .clk(clk),
    .srst(srst),
    .ce(ce),
    .in_valid(wr_valid),
    .in_ready(wr_ready),
    .in_data(wr_data),
    .out_valid(fifo_v),
    .out_ready(pop),
    .out_data(fifo_d)
  );

endmodule : nbm_host

// >>> nbm_host_asserts.sv
`timescale 1ns/1ps
module nbm_host_asserts import nbm_pkg::*; (
  input wire logic clk,
  input wire logic srst,
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire logic [2:0] cmd_op,
  input wire logic wp_allow,
  input wire logic done,
  input wire logic err_refused,
  input wire logic rd_valid,
  input wire logic nf_ce_n,
  input wire logic nf_cle,
  input wire logic nf_we_n,
  input wire logic read_strobe_n,
  input wire logic nf_wp_n,
  input wire logic [7:0] nf_dq_o,
  input wire logic nf_dq_oe,
  input wire logic nf_rb_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  wire take = cmd_valid && cmd_ready;
  wire confirm = nf_cle && (nf_dq_o inside {CMD_READ2, CMD_PROG2, CMD_ERASE2});
  property p_take_drop;
    take |=> !cmd_ready;
  endproperty
  a_take_drop: assert property (p_take_drop) else $error("ready held after take");
  property p_bad_op;
    take && cmd_op > 3'h5 |-> nf_ce_n [*3] ##0 (done && err_refused);
  endproperty
  a_bad_op: assert property (p_bad_op) else $error("bad op not refused");
  property p_wp_refuse;
    take && !wp_allow && (cmd_op inside {3'h1, 3'h2}) |-> nf_ce_n [*3] ##0 (done && err_refused);
  endproperty
  a_wp_refuse: assert property (p_wp_refuse) else $error("protected op not refused");
  property p_wp_stable;
    !nf_ce_n && !$past(nf_ce_n) |-> $stable(nf_wp_n);
  endproperty
  a_wp_stable: assert property (p_wp_stable) else $error("protect pin moved");
  property p_confirm_quiet;
    !nf_we_n && confirm ##1 nf_we_n |=> (nf_we_n && read_strobe_n) [*8];
  endproperty
  a_confirm_quiet: assert property (p_confirm_quiet) else $error("strobe inside busy onset");
  property p_busy_quiet;
    !nf_rb_n [*4] |-> nf_we_n || (nf_cle && (nf_dq_o inside {CMD_STATUS, CMD_RESET}));
  endproperty
  a_busy_quiet: assert property (p_busy_quiet) else $error("write while busy");
  property p_dq_dir;
    nf_dq_oe |-> read_strobe_n;
  endproperty
  a_dq_dir: assert property (p_dq_dir) else $error("bus fight");
  property p_rd_gap;
    rd_valid |=> !rd_valid [*7];
  endproperty
  a_rd_gap: assert property (p_rd_gap) else $error("read bytes too close");
endmodule : nbm_host_asserts

bind nbm_host nbm_host_asserts u_nbm_host_asserts (.clk(clk), .srst(srst), .cmd_valid(cmd_valid),
  .cmd_ready(cmd_ready), .cmd_op(cmd_op), .wp_allow(wp_allow), .done(done), .err_refused(err_refused),
  .rd_valid(rd_valid), .nf_ce_n(nf_ce_n), .nf_cle(nf_cle), .nf_we_n(nf_we_n), .read_strobe_n(read_strobe_n),
  .nf_wp_n(nf_wp_n), .nf_dq_o(nf_dq_o), .nf_dq_oe(nf_dq_oe), .nf_rb_n(nf_rb_n));

// >>> nbm_flash_model.sv
`timescale 1ns/1ps
module nbm_flash_model import nbm_pkg::*; #(
  parameter int BUSY_CYC = 40,
  parameter int SLOW_CYC = 2000
) (
  input wire logic clk,
  input wire logic ce_n,
  input wire logic cle,
  input wire logic ale,
  input wire logic we_n,
  input wire logic re_n,
  input wire logic wp_n,
  input wire logic [7:0] dq_in,
  input wire logic slow,
  input wire logic fail_en,
  input wire logic [7:0] mark,
  output logic [7:0] dq,
  output logic rb_n
);
  logic we_q = 1'b1, re_q = 1'b1, sts_q = 1'b0, fail_q = 1'b0;
  logic [7:0] cmd_q = 8'h00, last_q = 8'h00;
  logic [2:0] na_q = 3'h0, nd_q = 3'h0;
  logic [11:0] col_q = 12'h000;
  int busy_q = 0, lim_q = BUSY_CYC;
  wire we_rise = we_n && !we_q && !ce_n;
  wire re_rise = re_n && !re_q && !ce_n;
  wire go = we_rise && ((cle && (dq_in inside {CMD_READ2, CMD_PROG2, CMD_ERASE2, CMD_RESET}))
    || (ale && cmd_q == CMD_GETF) || (!cle && !ale && cmd_q == CMD_SETF && nd_q == 3'h3));
  wire [7:0] sts = {wp_n, rb_n, rb_n, 4'h0, fail_q};
  wire [7:0] arr = (col_q == SPARE_COL) ? mark : col_q[7:0] ^ 8'h5a;
  // Released bus shows a changing pattern, never the last byte
  assign dq = (!ce_n && !re_n) ? (sts_q ? sts : arr) : ~last_q;
  assign rb_n = !(busy_q != 0 && busy_q <= lim_q);
  always @(posedge clk) begin
    we_q <= we_n;
    re_q <= re_n;
    last_q <= dq;
    if (busy_q != 0) busy_q <= busy_q - 1;
    if (re_rise) col_q <= col_q + 12'h001;
    if (we_rise && cle) begin
      cmd_q <= dq_in;
      na_q <= 3'h0;
      nd_q <= 3'h0;
      sts_q <= (dq_in == CMD_STATUS);
      if (dq_in == CMD_PROG2 || dq_in == CMD_ERASE2) fail_q <= fail_en;
      if (dq_in == CMD_RESET) fail_q <= 1'b0;
    end
    if (we_rise && ale) begin
      na_q <= na_q + 3'h1;
      if (na_q == 3'h0) col_q[7:0] <= dq_in;
      if (na_q == 3'h1) col_q[11:8] <= dq_in[3:0];
    end
    if (we_rise && !cle && !ale) nd_q <= nd_q + 3'h1;
    if (go) begin
      lim_q <= slow ? SLOW_CYC : BUSY_CYC;
      busy_q <= (slow ? SLOW_CYC : BUSY_CYC) + 3;
    end
  end
endmodule : nbm_flash_model

// >>> nbm_host_tb.sv
`timescale 1ns/1ps
module nbm_host_tb import nbm_pkg::*;;
  logic clk = 1'b0, srst = 1'b1, cmd_valid = 1'b0, wp_allow = 1'b1, wr_valid = 1'b0, slow = 1'b0, fail_en = 1'b0;
  logic [2:0] cmd_op = 3'h0;
  logic [10:0] cmd_block = 11'h000;
  logic [5:0] cmd_page = 6'h00;
  logic [11:0] cmd_col = 12'h000, cmd_len = 12'h000;
  logic [7:0] wr_data = 8'h00, mark = 8'hff;
  logic cmd_ready, wr_ready, rd_valid, done, err_timeout, err_fail, err_order, err_nop, err_refused, mark_bad;
  logic ecc_valid, nf_ce_n, nf_cle, nf_ale, nf_we_n, read_strobe_n, nf_wp_n, nf_dq_oe, nf_rb_n;
  logic [7:0] rd_data, status_byte, nf_dq_o, mdl_dq;
  logic [17:0] ecc_syn, syn_seen;
  logic [7:0] rdq[$];
  int fail_count = 0, n_compared = 0, cyc = 0, got, k;
  wire [7:0] dq_bus = nf_dq_oe ? nf_dq_o : mdl_dq;
  always #2.5 clk = ~clk;
  nbm_host #(.READ_TMO_CYC(200), .PROG_TMO_CYC(400), .ERASE_TMO_CYC(800), .RESET_TMO_CYC(400)) u_nbm_host (
    .clk(clk), .srst(srst), .ce(1'b1), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
    .cmd_block(cmd_block), .cmd_page(cmd_page), .cmd_col(cmd_col), .cmd_len(cmd_len), .wp_allow(wp_allow),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data), .rd_valid(rd_valid), .rd_data(rd_data),
    .done(done), .status_byte(status_byte), .err_timeout(err_timeout), .err_fail(err_fail),
    .err_order(err_order), .err_nop(err_nop), .err_refused(err_refused), .mark_bad(mark_bad),
    .ecc_valid(ecc_valid), .ecc_syn(ecc_syn), .nf_ce_n(nf_ce_n), .nf_cle(nf_cle), .nf_ale(nf_ale),
    .nf_we_n(nf_we_n), .read_strobe_n(read_strobe_n), .nf_wp_n(nf_wp_n), .nf_dq_o(nf_dq_o),
    .nf_dq_oe(nf_dq_oe), .nf_dq_i(dq_bus), .nf_rb_n(nf_rb_n));
  nbm_flash_model u_nbm_flash_model (.clk(clk), .ce_n(nf_ce_n), .cle(nf_cle), .ale(nf_ale), .we_n(nf_we_n),
    .re_n(read_strobe_n), .wp_n(nf_wp_n), .dq_in(dq_bus), .slow(slow), .fail_en(fail_en), .mark(mark),
    .dq(mdl_dq), .rb_n(nf_rb_n));
  always @(negedge clk) begin
    if (rd_valid === 1'b1) rdq.push_back(rd_data);
    if (ecc_valid === 1'b1) syn_seen = ecc_syn;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      fail_count++;
      close_out();
    end
  end
  task automatic close_out();
    if (fail_count == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %0t %s: got %0h want %0h", $time, what, seen, exp);
    end
  endtask : chk
  function automatic logic [7:0] exp_byte(input logic [11:0] c);
    return (c == SPARE_COL) ? mark : c[7:0] ^ 8'h5a;
  endfunction : exp_byte
  task automatic feed(input int n);
    got = 0;
    wr_valid = 1'b1;
    for (int i = 0; i < n + 4 && got < n; i++) begin
      wr_data = 8'($urandom);
      if (wr_ready === 1'b1) got++;
      @(negedge clk);
    end
    wr_valid = 1'b0;
  endtask : feed
  task automatic run(input logic [2:0] op, input logic [10:0] blk, input logic [5:0] pg, input logic [11:0] col,
                     input logic [11:0] len);
    int i;
    {cmd_op, cmd_block, cmd_page, cmd_col, cmd_len} = {op, blk, pg, col, len};
    cmd_valid = 1'b1;
    for (i = 0; i < 100 && cmd_ready !== 1'b1; i++) @(negedge clk);
    @(negedge clk);
    cmd_valid = 1'b0;
    for (i = 0; i < 20000 && done !== 1'b1; i++) @(negedge clk);
    chk(done, 1'b1, "no done");
  endtask : run
  task automatic rd_chk(input logic [11:0] col, input logic [11:0] len);
    logic [7:0] x, b;
    logic [9:0] ix;
    x = 8'h00;
    ix = 10'h000;
    rdq.delete();
    syn_seen = 'x;
    run(OP_READ, 11'($urandom), 6'($urandom), col, len);
    chk(rdq.size(), len, "read count");
    for (int i = 0; i < len; i++) begin
      b = exp_byte(col + 12'(i));
      x ^= b;
      if (^b) ix ^= 10'(i);
      chk(rdq[i], b, "read byte");
    end
    chk(syn_seen, {ix, x}, "syndrome");
  endtask : rd_chk
  initial begin
    void'($urandom(32'h5adb));
    repeat (16) @(negedge clk);
    srst = 1'b0;
    @(negedge clk);
    rd_chk(12'h7fe, 12'h003);
    repeat (3) rd_chk(12'($urandom_range(0, 2040)), 12'($urandom_range(1, 8)));
    repeat (3) begin
      mark = ($urandom_range(0, 1) == 1) ? 8'hff : 8'($urandom);
      rd_chk(SPARE_COL, 12'h001);
      chk(mark_bad, mark != 8'hff, "mark");
    end
    feed(17);
    chk(got, 16, "fifo fill");
    chk(wr_ready, 1'b0, "fifo full");
    run(OP_PROG, 11'h007, 6'h09, 12'h000, 12'h010);
    chk(err_fail, 1'b0, "prog");
    chk(status_byte[STS_RDY_BIT], 1'b1, "ready bit");
    chk(wr_ready, 1'b1, "fifo drained");
    for (k = 2; k <= 5; k++) begin
      if (k < 5) feed(1);
      run(OP_PROG, 11'h007, 6'h09, 12'h000, 12'h001);
      chk(err_nop, k == 5, "partial count");
    end
    run(OP_PROG, 11'h007, 6'h08, 12'h000, 12'h001);
    chk(err_order, 1'b1, "page order");
    fail_en = 1'b1;
    feed(1);
    run(OP_PROG, 11'h007, 6'h0a, 12'h000, 12'h001);
    chk(err_fail, 1'b1, "prog fail");
    fail_en = 1'b0;
    for (k = 0; k < 5; k++) begin
      wp_allow = (k > 1);
      run(k < 2 ? 3'(k + 1) : (k < 4 ? 3'(k + 4) : 3'h0), 11'h007, 6'h0b, 12'h000, 12'(k < 4));
      chk(err_refused, 1'b1, "refused");
    end
    run(OP_ERASE, 11'h007, 6'h00, 12'h000, 12'h000);
    chk(err_fail, 1'b0, "erase");
    feed(1);
    run(OP_PROG, 11'h007, 6'h00, 12'h000, 12'h001);
    chk(err_order, 1'b0, "first page");
    feed(4);
    run(OP_SETF, 11'h000, 6'h00, 12'h080, 12'h004);
    chk(err_timeout, 1'b0, "set feature");
    rdq.delete();
    run(OP_GETF, 11'h000, 6'h00, 12'h080, 12'h004);
    chk(rdq.size(), 4, "get feature");
    slow = 1'b1;
    run(OP_READ, 11'h001, 6'h00, 12'h000, 12'h001);
    chk(err_timeout, 1'b1, "busy timeout");
    slow = 1'b0;
    for (k = 0; k < 3000 && nf_rb_n !== 1'b1; k++) @(negedge clk);
    run(OP_RESET, 11'h000, 6'h00, 12'h000, 12'h000);
    chk(err_timeout, 1'b0, "reset");
    close_out();
  end
endmodule : nbm_host_tb
